// ### rtl/eam_map.svh
// register offsets, field positions, reset values and bus codes of the
// energy accumulation mode block; definitions only, included by eam_top.
`ifndef EAM_MAP_SVH
`define EAM_MAP_SVH

// byte offsets on the register bus
`define EAM_OFF_MODE 8'h00
`define EAM_OFF_SAG 8'h04
`define EAM_OFF_STATUS 8'h08
`define EAM_OFF_MASK 8'h0c
`define EAM_OFF_TERM 8'h10
`define EAM_OFF_A_ACT 8'h14
`define EAM_OFF_A_REA 8'h18
`define EAM_OFF_A_APP 8'h1c

// mode register: bit 7 reserved, so only the low seven bits store
`define EAM_MODE_RSVD_BIT 7
`define EAM_MODE_WMASK 8'h7f
`define EAM_MODE_RST 8'h00
`define EAM_SAG_RST 16'h0000
`define EAM_TERM_RST 3'h7
`define EAM_MASK_RST 2'h0

// status bit positions
`define EAM_ST_SAG 0
`define EAM_ST_SAMPLE 1

// bus responses
`define EAM_RESP_OKAY 2'h0
`define EAM_RESP_SLVERR 2'h2

`endif

// ### rtl/eam_pkg.sv
// types of the energy accumulation mode block: mode codes and the
// layout of the accumulation mode register; no logic.
package eam_pkg;

  typedef enum logic [1:0] {
    eam_wye4 = 2'b00,
    eam_delta3 = 2'b01,
    eam_wiring_rsvd = 2'b10,
    eam_delta4 = 2'b11
  } eam_wiring_e;

  typedef enum logic [1:0] {
    eam_var_signed = 2'b00,
    eam_var_rsvd = 2'b01,
    eam_var_by_active = 2'b10,
    eam_var_abs = 2'b11
  } eam_var_e;

  typedef struct packed {
    logic reserved;
    logic sag_flag_style;
    eam_wiring_e wiring_select;
    eam_var_e reactive_accum_style;
    logic [1:0] active_accum_style;
  } eam_mode_s;

endpackage

// ### rtl/eam_top.sv
// energy accumulation mode block: mode register on AXI4-Lite, wiring
// selection of accumulator inputs, reactive signing, sag flag, interrupt.
// assumes samples and rms values come from logic on the same clock.
`timescale 1ns/1ps
`include "eam_map.svh"

module eam_top #(
  parameter int SW = 16,
  parameter int RMS_W = 16,
  parameter int ACC_W = 48,
  parameter int QD = 20
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sample_valid,
  input wire logic [2:0][SW-1:0] volt,
  input wire logic [2:0][SW-1:0] cur,
  input wire logic [2:0][RMS_W-1:0] volt_rms,
  input wire logic [2:0][RMS_W-1:0] cur_rms,
  input wire logic [RMS_W-1:0] line_ac_rms,
  output logic [2:0][ACC_W-1:0] active_energy,
  output logic [2:0][ACC_W-1:0] reactive_energy,
  output logic [2:0][ACC_W-1:0] apparent_energy,
  output logic [2:0][ACC_W-1:0] reactive_term,
  output logic [2:0] converter_term_enables,
  output logic [SW:0] phase_b_rms_source,
  output logic [RMS_W-1:0] phase_b_volt_rms,
  output logic irq
);

  typedef struct packed {
    eam_pkg::eam_mode_s mode;
    logic [SW-1:0] sag_thr;
    logic [1:0] status;
    logic [1:0] mask;
    logic [2:0] term_en;
    logic [2:0] below;
    logic [QD-1:0][2:0][SW:0] qdly;
    logic [2:0][ACC_W-1:0] act;
    logic [2:0][ACC_W-1:0] rea;
    logic [2:0][ACC_W-1:0] app;
    logic [2:0][ACC_W-1:0] var_term;
    logic [RMS_W-1:0] b_rms;
    logic [SW:0] vb_src;
    logic irq;
    logic have_aw;
    logic have_w;
    logic [7:0] aw_addr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } eam_state_s;

  localparam eam_state_s ST_RST = '{term_en: `EAM_TERM_RST, mask: `EAM_MASK_RST,
                                   sag_thr: `EAM_SAG_RST, default: '0};

  logic rst_meta;
  logic rst_sync;
  eam_state_s st;
  eam_state_s next_st;
  logic signed [SW:0] vsel [3];
  logic signed [SW:0] isel [3];
  logic signed [SW:0] va_ext;
  logic [2:0] below_now;

  // byte-lane merge for register writes
  function automatic logic [31:0] eam_merge(input logic [31:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  assign va_ext = {volt[0][SW-1], volt[0]};

  // accumulator input selection by wiring style
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      vsel[p] = $signed({volt[p][SW-1], volt[p]});
      isel[p] = $signed({cur[p][SW-1], cur[p]});
    end
    unique case (st.mode.wiring_select)
      eam_pkg::eam_delta3: begin
        vsel[1] = (SW+1)'(va_ext - $signed({volt[2][SW-1], volt[2]}));
        isel[1] = '0;
      end
      eam_pkg::eam_delta4: begin
        vsel[1] = (SW+1)'(-va_ext);
      end
      eam_pkg::eam_wye4, eam_pkg::eam_wiring_rsvd: begin
        // reserved code behaves as wye so the meter keeps running
        vsel[1] = $signed({volt[1][SW-1], volt[1]});
      end
    endcase
    // magnitude below threshold per phase, shared with the sag checks
    for (int p = 0; p < 3; p++) begin
      below_now[p] = (vsel[p][SW] ? (SW+1)'(-vsel[p]) : vsel[p]) < {1'b0, st.sag_thr};
    end
  end

  // next state: bus slave, sample processing, sag and interrupt
  always_comb begin
    logic [31:0] wv;
    logic [1:0] clr;
    logic [1:0] set;
    logic sag_set;
    logic signed [2*SW+1:0] pw;
    logic signed [2*SW+1:0] qv;
    logic [2*RMS_W-1:0] sv;
    logic [RMS_W-1:0] rms_v;
    next_st = st;
    wv = '0;
    clr = '0;
    set = '0;
    sag_set = 1'b0;
    pw = '0;
    qv = '0;
    sv = '0;
    rms_v = '0;

    // write channels are taken in either order, then answered together
    if (s_axi_awvalid && st.awready) begin
      next_st.have_aw = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.have_w = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.have_aw && st.have_w && !st.bvalid) begin
      next_st.have_aw = 1'b0;
      next_st.have_w = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = `EAM_RESP_OKAY;
      unique case ({st.aw_addr[7:2], 2'b00})
        `EAM_OFF_MODE: begin
          wv = eam_merge({24'h0, st.mode}, st.wdata, st.wstrb);
          next_st.mode = eam_pkg::eam_mode_s'(wv[7:0] & `EAM_MODE_WMASK);
        end
        `EAM_OFF_SAG: begin
          wv = eam_merge({{(32-SW){1'b0}}, st.sag_thr}, st.wdata, st.wstrb);
          next_st.sag_thr = wv[SW-1:0];
        end
        `EAM_OFF_STATUS: begin
          wv = eam_merge(32'h0, st.wdata, st.wstrb);
          clr = wv[1:0];
        end
        `EAM_OFF_MASK: begin
          wv = eam_merge({30'h0, st.mask}, st.wdata, st.wstrb);
          next_st.mask = wv[1:0];
        end
        `EAM_OFF_TERM: begin
          // phase B enable is left to software in delta wiring
          wv = eam_merge({29'h0, st.term_en}, st.wdata, st.wstrb);
          next_st.term_en = wv[2:0];
        end
        default: begin
          next_st.bresp = `EAM_RESP_SLVERR;
        end
      endcase
    end

    // read: one cycle from address to data
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = `EAM_RESP_OKAY;
      unique case ({s_axi_araddr[7:2], 2'b00})
        `EAM_OFF_MODE: next_st.rdata = {24'h0, st.mode};
        `EAM_OFF_SAG: next_st.rdata = {{(32-SW){1'b0}}, st.sag_thr};
        `EAM_OFF_STATUS: next_st.rdata = {30'h0, st.status};
        `EAM_OFF_MASK: next_st.rdata = {30'h0, st.mask};
        `EAM_OFF_TERM: next_st.rdata = {29'h0, st.term_en};
        `EAM_OFF_A_ACT: next_st.rdata = st.act[0][31:0];
        `EAM_OFF_A_REA: next_st.rdata = st.rea[0][31:0];
        `EAM_OFF_A_APP: next_st.rdata = st.app[0][31:0];
        default: begin
          next_st.rdata = 32'h0;
          next_st.rresp = `EAM_RESP_SLVERR;
        end
      endcase
    end

    // one sample updates delay line, accumulators and sag tracking
    if (sample_valid) begin
      set[`EAM_ST_SAMPLE] = 1'b1;
      for (int k = QD - 1; k > 0; k--) begin
        next_st.qdly[k] = st.qdly[k-1];
      end
      for (int p = 0; p < 3; p++) begin
        next_st.qdly[0][p] = isel[p];
        pw = vsel[p] * isel[p];
        qv = vsel[p] * $signed(st.qdly[QD-1][p]);
        // delayed B currents may predate a switch into three-wire delta, so zero here too
        if (p == 1 && st.mode.wiring_select == eam_pkg::eam_delta3) begin
          qv = '0;
        end
        unique case (st.mode.reactive_accum_style)
          eam_pkg::eam_var_by_active: qv = (pw < 0) ? -qv : qv;
          eam_pkg::eam_var_abs: qv = (qv < 0) ? -qv : qv;
          eam_pkg::eam_var_signed, eam_pkg::eam_var_rsvd: qv = qv;
        endcase
        next_st.var_term[p] = ACC_W'(qv);
        next_st.act[p] = st.act[p] + ACC_W'(pw);
        next_st.rea[p] = st.rea[p] + ACC_W'(qv);
        if (below_now[p]) begin
          next_st.below[p] = 1'b1;
        end else if (st.below[p]) begin
          next_st.below[p] = 1'b0;
          sag_set = sag_set | st.mode.sag_flag_style;
        end
      end
      if (!st.mode.sag_flag_style && |below_now) begin
        sag_set = 1'b1;
      end
      set[`EAM_ST_SAG] = sag_set;
      // apparent: phase B rms follows the wiring
      for (int p = 0; p < 3; p++) begin
        rms_v = volt_rms[p];
        if (p == 1 && st.mode.wiring_select == eam_pkg::eam_delta3) begin
          rms_v = line_ac_rms;
        end else if (p == 1 && st.mode.wiring_select == eam_pkg::eam_delta4) begin
          rms_v = volt_rms[0];
        end
        sv = rms_v * cur_rms[p];
        next_st.app[p] = st.app[p] + ACC_W'(sv);
        if (p == 1) begin
          next_st.b_rms = rms_v;
        end
      end
      next_st.vb_src = vsel[1];
    end

    // sticky status: a new event wins over a clear in the same cycle
    next_st.status = (st.status & ~clr) | set;
    next_st.irq = |(next_st.status & next_st.mask);
    next_st.awready = !next_st.have_aw && !next_st.bvalid;
    next_st.wready = !next_st.have_w && !next_st.bvalid;
    next_st.arready = !next_st.rvalid;
  end

  // all block state but the reset synchronizer in one register; ce low freezes it
  always_ff @(posedge clock or negedge rst_sync) begin
    if (!rst_sync) begin
      st <= ST_RST;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign active_energy = st.act;
  assign reactive_energy = st.rea;
  assign apparent_energy = st.app;
  assign reactive_term = st.var_term;
  assign converter_term_enables = st.term_en;
  assign phase_b_rms_source = st.vb_src;
  assign phase_b_volt_rms = st.b_rms;
  assign irq = st.irq;

  default clocking eam_cb @(posedge clock); endclocking
  default disable iff (!rst_sync);

  irq_level_a: assert property (irq == |(st.status & st.mask))
    else $error("interrupt does not match masked status");
  mode_rsvd_bit_a: assert property (st.mode.reserved == 1'b0)
    else $error("reserved mode bit was stored");
  delta3_b_zero_a: assert property (
    ce && sample_valid && st.mode.wiring_select == eam_pkg::eam_delta3
    |=> reactive_term[1] == '0 && $stable(active_energy[1]))
    else $error("phase b power not zero in three-wire delta");
  sag_level_a: assert property (
    ce && sample_valid && !st.mode.sag_flag_style && (|below_now)
    |=> st.status[`EAM_ST_SAG])
    else $error("sag flag missed while voltage below threshold");
  sag_edge_a: assert property (
    ce && sample_valid && st.mode.sag_flag_style && !st.status[`EAM_ST_SAG]
    && !(|(st.below & ~below_now))
    |=> !st.status[`EAM_ST_SAG])
    else $error("sag flag set without a rise above threshold");
  abs_var_a: assert property (
    ce && sample_valid && st.mode.reactive_accum_style == eam_pkg::eam_var_abs
    |=> !reactive_term[0][ACC_W-1] && !reactive_term[1][ACC_W-1]
        && !reactive_term[2][ACC_W-1])
    else $error("negative reactive term in absolute style");
  delta4_vb_a: assert property (
    ce && sample_valid && st.mode.wiring_select == eam_pkg::eam_delta4
    |=> phase_b_rms_source == (SW+1)'(-$past(va_ext)))
    else $error("phase b voltage not negated phase a");
  delta3_rms_a: assert property (
    ce && sample_valid && st.mode.wiring_select == eam_pkg::eam_delta3
    |=> phase_b_volt_rms == $past(line_ac_rms))
    else $error("phase b rms is not the line rms");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata))
    else $error("read data dropped before acceptance");

endmodule

// ### verification/test_energy_accum_mode_config.sv
// self-checking bench of the energy accumulation mode block: registers,
// wiring selection, reactive signing, sag flag and interrupt.
// assumes eam_top with its quarter-period delay cut to two samples.
`timescale 1ns/1ps
`include "eam_map.svh"

module test_energy_accum_mode_config;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, sample_valid = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, r;
  logic [2:0][15:0] volt = '0, cur = '0, volt_rms = '0, cur_rms = '0;
  logic [15:0] line_ac_rms = 16'h0, phase_b_volt_rms;
  logic [16:0] phase_b_rms_source;
  logic [2:0][47:0] act_e, app_e, rea_t, rea_e;
  logic [2:0] term_en;
  int fails = 0, checked = 0, cyc = 0;

  always #5 clock = ~clock;

  // full byte strobes and a running clock enable are the only ties
  eam_top #(.QD(2)) i_eam_top (.clock(clock), .rst_n(rst_n), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sample_valid(sample_valid), .volt(volt), .cur(cur), .volt_rms(volt_rms),
    .cur_rms(cur_rms), .line_ac_rms(line_ac_rms), .active_energy(act_e),
    .reactive_energy(rea_e), .apparent_energy(app_e), .reactive_term(rea_t),
    .converter_term_enables(term_en), .phase_b_rms_source(phase_b_rms_source),
    .phase_b_volt_rms(phase_b_volt_rms), .irq(irq));

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      $display("[FAIL] %0t timeout", $time);
      end_of_test();
    end
  end

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  // each channel released only at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clock);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clock);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clock); while (rvalid !== 1'b1);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a, d, r);
    chk(d, e);
    chk(r, `EAM_RESP_OKAY);
  endtask

  // a mid-run reset also clears the accumulators between scenarios
  task automatic rst;
    rst_n <= 1'b0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
  endtask

  // n sample strobes, then one edge so the results have landed
  task automatic smp(input int n);
    repeat (n) begin
      @(posedge clock);
      sample_valid <= 1'b1;
      @(posedge clock);
      sample_valid <= 1'b0;
    end
    @(posedge clock);
  endtask

  task automatic test_regs;
    rchk(`EAM_OFF_MODE, 32'h0);
    rchk(`EAM_OFF_TERM, 32'h7);
    wr(`EAM_OFF_MODE, 32'hff, r);
    rchk(`EAM_OFF_MODE, 32'h7f);
    wr(`EAM_OFF_TERM, 32'h5, r);
    rchk(`EAM_OFF_TERM, 32'h5);
    chk(term_en, 3'h5);
    wr(`EAM_OFF_A_ACT, 32'h1, r);
    chk(r, `EAM_RESP_SLVERR);
    rd(8'h40, d, r);
    chk(r, `EAM_RESP_SLVERR);
    chk(d, 32'h0);
  endtask

  // every wiring code, reserved one included, with a live phase B current
  task automatic test_wiring;
    int vb;
    for (int w = 0; w < 4; w++) begin
      rst();
      wr(`EAM_OFF_MODE, 32'(w << 4), r);
      volt <= {16'hfed4, 16'd200, 16'd100};
      cur <= {16'd7, 16'd5, 16'd3};
      volt_rms <= {16'd1200, 16'd1100, 16'd1000};
      cur_rms <= {16'd30, 16'd20, 16'd10};
      line_ac_rms <= 16'd1500;
      smp(1);
      vb = (w == 1) ? 0 : (w == 3) ? -100 : 200;
      chk(act_e[0], 48'd300);
      chk(act_e[2], 48'(-2100));
      chk(act_e[1], 48'(vb * 5));
      chk(app_e[0], 48'd10000);
      chk(phase_b_volt_rms, (w == 1) ? 1500 : (w == 3) ? 1000 : 1100);
      if (w == 0) chk(app_e[1], 48'd22000);
      if (w == 1) chk(phase_b_rms_source, 17'd400);
      if (w == 3) chk(phase_b_rms_source, 17'h1ff9c);
    end
  endtask

  // negative product: signing styles differ; reserved 01 acts as signed
  task automatic test_reactive;
    logic [47:0] ex [4] = '{48'(-500), 48'(-500), 48'd500, 48'd500};
    rst();
    volt <= {16'h0, 16'h0, 16'd100};
    cur <= {16'h0, 16'h0, 16'hfffb};
    for (int s = 0; s < 4; s++) begin
      wr(`EAM_OFF_MODE, 32'(s << 2), r);
      smp(3);
      chk(rea_t[0], ex[s]);
    end
    cur[0] <= 16'd9;
    smp(1);
    chk(rea_t[0], 48'd500);
    smp(2);
    chk(rea_t[0], 48'd900);
    chk(rea_e[0], 48'd2900);
    rchk(`EAM_OFF_A_REA, 32'd2900);
    // live phase B current in the delay line, then a switch into delta
    cur[1] <= 16'd4;
    smp(2);
    wr(`EAM_OFF_MODE, 32'h1c, r);
    smp(1);
    chk(rea_t[1], 48'd0);
  endtask

  task automatic test_sag;
    rst();
    wr(`EAM_OFF_SAG, 32'd100, r);
    wr(`EAM_OFF_MASK, 32'h1, r);
    volt <= {16'd500, 16'hfe0c, 16'd500};
    smp(1);
    rchk(`EAM_OFF_STATUS, 32'h2);
    chk(irq, 1'b0);
    volt[1] <= 16'hffce;
    smp(1);
    rchk(`EAM_OFF_STATUS, 32'h3);
    chk(irq, 1'b1);
    wr(`EAM_OFF_STATUS, 32'h3, r);
    rchk(`EAM_OFF_STATUS, 32'h0);
    chk(irq, 1'b0);
    wr(`EAM_OFF_MODE, 32'h40, r);
    smp(1);
    rchk(`EAM_OFF_STATUS, 32'h2);
    volt[1] <= 16'd500;
    smp(1);
    rchk(`EAM_OFF_STATUS, 32'h3);
    chk(irq, 1'b1);
    wr(`EAM_OFF_MASK, 32'h0, r);
    chk(irq, 1'b0);
  endtask

  initial begin
    rst();
    test_regs();
    test_wiring();
    test_reactive();
    test_sag();
    end_of_test();
  end
endmodule
